// ### pss_defs.vh
// Constants for the pressure sensor serial slave port
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH
`define PSS_ADDR_W          7
`define PSS_A_REF_LOW       7'h08
`define PSS_A_REF_MID       7'h09
`define PSS_A_REF_HIGH      7'h0A
`define PSS_A_IDENTITY      7'h0F
`define PSS_A_AVG_CFG       7'h10
`define PSS_A_CTRL_ONE      7'h20
`define PSS_A_CTRL_TWO      7'h21
`define PSS_A_CTRL_THREE    7'h22
`define PSS_A_CTRL_FOUR     7'h23
`define PSS_A_IRQ_CFG       7'h24
`define PSS_A_IRQ_SRC       7'h25
`define PSS_A_STATUS        7'h27
`define PSS_A_P_OUT_LOW     7'h28
`define PSS_A_P_OUT_MID     7'h29
`define PSS_A_P_OUT_HIGH    7'h2A
`define PSS_A_T_OUT_LOW     7'h2B
`define PSS_A_T_OUT_HIGH    7'h2C
`define PSS_A_QUEUE_CTRL    7'h2E
`define PSS_A_QUEUE_STAT    7'h2F
`define PSS_A_THS_LOW       7'h30
`define PSS_A_THS_HIGH      7'h31
`define PSS_A_OFS_LOW       7'h39
`define PSS_A_OFS_HIGH      7'h3A
`define PSS_RST_ZERO        8'h00
`define PSS_RST_AVG_CFG     8'h05
`define PSS_RST_OFS_LOW     8'h38
`define PSS_BIT_THREE_WIRE  0
`define PSS_BIT_READ        7
`define PSS_BIT_INCR        6
`define PSS_CMD_BITS        4'h8
`define PSS_ID_VALUE        8'h5A
`endif

// ### pss_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pss_sync
#(
   parameter RESET_VAL = 1'b0
)
(
   input  wire i_mclk,
   input  wire i_srst,
   input  wire i_pin,
   output reg  o_level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // First stage feeds only the second; level moves when stages two and three agree
   always @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         s1_q    <= RESET_VAL;
         s2_q    <= RESET_VAL;
         s3_q    <= RESET_VAL;
         o_level <= RESET_VAL;
      end
      else
      begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            o_level <= s3_q;
      end
   end
endmodule // pss_sync

// ### pss_buf2.v
// Two-entry valid/ready buffer
`timescale 1ns/1ns
module pss_buf2
#(
   parameter WIDTH = 15
)
(
   input  wire             i_mclk,
   input  wire             i_srst,
   input  wire             i_valid,
   output wire             o_ready,
   input  wire [WIDTH-1:0] i_data,
   output wire             o_valid,
   input  wire             i_ready,
   output wire [WIDTH-1:0] o_data
);
   reg [WIDTH-1:0] mem_q [0:1];
   reg             wr_q;
   reg             rd_q;
   reg [1:0]       cnt_q;
   wire            push;
   wire            pop;

   assign o_ready = (cnt_q != 2'd2);
   assign o_valid = (cnt_q != 2'd0);
   assign o_data  = mem_q[rd_q];
   assign push    = i_valid & o_ready;
   assign pop     = o_valid & i_ready;

   // Pointers and occupancy; full stalls the source
   always @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'd0;
      end
      else
      begin
         if (push)
            wr_q <= ~wr_q;
         if (pop)
            rd_q <= ~rd_q;
         if (push & ~pop)
            cnt_q <= cnt_q + 2'd1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 2'd1;
      end
   end

   // Storage has no reset; it is only read while valid
   always @(posedge i_mclk)
   begin
      if (push)
         mem_q[wr_q] <= i_data;
   end
endmodule // pss_buf2

// ### pss_spi_slave.v
// Serial slave port and register map of the pressure sensor
`timescale 1ns/1ns
`include "pss_defs.vh"
module pss_spi_slave
#(
   parameter ID_VALUE = `PSS_ID_VALUE  // Arbitrary identity value
)
(
   input  wire        i_mclk,
   input  wire        i_srst,
   input  wire        i_cs_n,
   input  wire        i_serial_port_clock,
   input  wire        i_serial_data_in,
   output reg         o_serial_data_in_out,
   output reg         o_serial_data_in_oe,
   output reg         o_serial_data_out,
   output reg         o_serial_data_out_oe,
   input  wire [23:0] i_pressure_raw,
   input  wire [15:0] i_temperature,
   input  wire [7:0]  i_status,
   input  wire [7:0]  i_irq_source,
   input  wire [7:0]  i_queue_status,
   output reg  [23:0] o_pressure_comp,
   output wire [23:0] o_ref_pressure_bits,
   output reg  [9:0]  o_pressure_avg_count,
   output reg  [6:0]  o_temperature_avg_count,
   output wire        o_three_wire_select,
   output wire [7:0]  o_control_one,
   output wire [7:0]  o_control_two,
   output wire [7:0]  o_control_three,
   output wire [7:0]  o_control_four,
   output wire [7:0]  o_irq_config,
   output wire [7:0]  o_queue_control,
   output wire [15:0] o_threshold,
   output wire [15:0] o_pressure_offset
);
   // Synchronised pins
   wire       cs_n_s;
   wire       sck_s;
   wire       sdi_s;
   reg        sck_prev_q;
   wire       sck_rise;
   wire       sck_fall;

   // Frame state
   reg [7:0]  cmd_q;
   reg [7:0]  shin_q;
   reg [7:0]  shout_q;
   reg [2:0]  bitcnt_q;
   reg        data_ph_q;
   reg        drive_q;
   reg        first_fall_q;
   reg [6:0]  addr_q;
   wire       is_read;

   // Registers
   reg [7:0]  ref_low_q;
   reg [7:0]  ref_mid_q;
   reg [7:0]  ref_high_q;
   reg [7:0]  avg_cfg_q;
   reg [7:0]  ctrl_one_q;
   reg [7:0]  ctrl_two_q;
   reg [7:0]  ctrl_three_q;
   reg [7:0]  ctrl_four_q;
   reg [7:0]  irq_cfg_q;
   reg [7:0]  queue_ctrl_q;
   reg [7:0]  ths_low_q;
   reg [7:0]  ths_high_q;
   reg [7:0]  ofs_low_q;
   reg [7:0]  ofs_high_q;
   reg [7:0]  rd_data;

   // Write buffer between serial capture and register file
   reg        wr_valid_d;
   reg [14:0] wr_word_d;
   wire       wr_ready;
   wire       wb_valid;
   wire [14:0] wb_word;

   pss_sync #(.RESET_VAL(1'b1)) u_sync_cs
   (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_pin   (i_cs_n),
      .o_level (cs_n_s)
   );

   pss_sync #(.RESET_VAL(1'b1)) u_sync_sck
   (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_pin   (i_serial_port_clock),
      .o_level (sck_s)
   );

   // In three-wire mode the shared pin carries command input
   pss_sync #(.RESET_VAL(1'b0)) u_sync_sdi
   (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_pin   (i_serial_data_in),
      .o_level (sdi_s)
   );

   pss_buf2 #(.WIDTH(15)) u_wbuf
   (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_valid (wr_valid_d),
      .o_ready (wr_ready),
      .i_data  (wr_word_d),
      .o_valid (wb_valid),
      .i_ready (1'b1),
      .o_data  (wb_word)
   );

   // Edge detection on the filtered clock level; edges ignored outside frames
   always @(posedge i_mclk)
   begin
      if (i_srst)
         sck_prev_q <= 1'b1;
      else
         sck_prev_q <= sck_s;
   end
   assign sck_rise = ~cs_n_s & sck_s & ~sck_prev_q;
   assign sck_fall = ~cs_n_s & ~sck_s & sck_prev_q;
   assign is_read  = cmd_q[`PSS_BIT_READ];

   // Read mux over the seven-bit address; reserved and unmapped read zero
   always @*
   begin
      case (addr_q)
         `PSS_A_REF_LOW:    rd_data = ref_low_q;
         `PSS_A_REF_MID:    rd_data = ref_mid_q;
         `PSS_A_REF_HIGH:   rd_data = ref_high_q;
         `PSS_A_IDENTITY:   rd_data = ID_VALUE[7:0];
         `PSS_A_AVG_CFG:    rd_data = avg_cfg_q;
         `PSS_A_CTRL_ONE:   rd_data = ctrl_one_q;
         `PSS_A_CTRL_TWO:   rd_data = ctrl_two_q;
         `PSS_A_CTRL_THREE: rd_data = ctrl_three_q;
         `PSS_A_CTRL_FOUR:  rd_data = ctrl_four_q;
         `PSS_A_IRQ_CFG:    rd_data = irq_cfg_q;
         `PSS_A_IRQ_SRC:    rd_data = i_irq_source;
         `PSS_A_STATUS:     rd_data = i_status;
         `PSS_A_P_OUT_LOW:  rd_data = o_pressure_comp[7:0];
         `PSS_A_P_OUT_MID:  rd_data = o_pressure_comp[15:8];
         `PSS_A_P_OUT_HIGH: rd_data = o_pressure_comp[23:16];
         `PSS_A_T_OUT_LOW:  rd_data = i_temperature[7:0];
         `PSS_A_T_OUT_HIGH: rd_data = i_temperature[15:8];
         `PSS_A_QUEUE_CTRL: rd_data = queue_ctrl_q;
         `PSS_A_QUEUE_STAT: rd_data = i_queue_status;
         `PSS_A_THS_LOW:    rd_data = ths_low_q;
         `PSS_A_THS_HIGH:   rd_data = ths_high_q;
         `PSS_A_OFS_LOW:    rd_data = ofs_low_q;
         `PSS_A_OFS_HIGH:   rd_data = ofs_high_q;
         default:           rd_data = `PSS_RST_ZERO;
      endcase
   end

   // Serial engine: capture on rise, shift out on fall
   always @(posedge i_mclk)
   begin
      wr_valid_d <= 1'b0;
      if (i_srst | cs_n_s)
      begin
         cmd_q        <= 8'h00;
         shin_q       <= 8'h00;
         shout_q      <= 8'h00;
         bitcnt_q     <= 3'd0;
         data_ph_q    <= 1'b0;
         drive_q      <= 1'b0;
         first_fall_q <= 1'b1;
         addr_q       <= 7'h00;
         wr_word_d    <= 15'h0000;
      end
      else
      begin
         // A rise before the frame's first fall is not a bit boundary
         if (sck_rise & ~first_fall_q)
         begin
            shin_q   <= {shin_q[6:0], sdi_s};
            bitcnt_q <= bitcnt_q + 3'd1;
            if (bitcnt_q == 3'd7)
            begin
               // One byte complete every 8 clocks
               data_ph_q <= 1'b1;
               if (!data_ph_q)
               begin
                  cmd_q  <= {shin_q[6:0], sdi_s};
                  addr_q <= {1'b0, shin_q[4:0], sdi_s};
               end
               else
               begin
                  if (!is_read)
                  begin
                     wr_valid_d <= wr_ready;
                     wr_word_d  <= {addr_q, shin_q[6:0], sdi_s};
                  end
                  if (cmd_q[`PSS_BIT_INCR])
                     addr_q <= addr_q + 7'd1;
               end
            end
         end
         if (sck_fall)
         begin
            first_fall_q <= 1'b0;
            // Byte boundary: load next read byte at start of bits 8, 16, ...
            if (data_ph_q & is_read & (bitcnt_q == 3'd0))
            begin
               shout_q <= {rd_data[6:0], 1'b0};
               o_serial_data_out    <= rd_data[7];
               o_serial_data_in_out <= rd_data[7];
               drive_q <= 1'b1;
            end
            else if (drive_q)
            begin
               shout_q <= {shout_q[6:0], 1'b0};
               o_serial_data_out    <= shout_q[7];
               o_serial_data_in_out <= shout_q[7];
            end
         end
      end
      if (i_srst)
      begin
         o_serial_data_out    <= 1'b0;
         o_serial_data_in_out <= 1'b0;
      end
   end

   // Drive only one pin in a read data phase, chosen by interface mode
   always @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         o_serial_data_out_oe <= 1'b0;
         o_serial_data_in_oe  <= 1'b0;
      end
      else
      begin
         o_serial_data_out_oe <= drive_q & ~cs_n_s & ~ctrl_one_q[`PSS_BIT_THREE_WIRE];
         o_serial_data_in_oe  <= drive_q & ~cs_n_s & ctrl_one_q[`PSS_BIT_THREE_WIRE];
      end
   end

   // Register file: reset loads defaults, including calibration offset
   always @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         ref_low_q    <= `PSS_RST_ZERO;
         ref_mid_q    <= `PSS_RST_ZERO;
         ref_high_q   <= `PSS_RST_ZERO;
         avg_cfg_q    <= `PSS_RST_AVG_CFG;
         ctrl_one_q   <= `PSS_RST_ZERO;
         ctrl_two_q   <= `PSS_RST_ZERO;
         ctrl_three_q <= `PSS_RST_ZERO;
         ctrl_four_q  <= `PSS_RST_ZERO;
         irq_cfg_q    <= `PSS_RST_ZERO;
         queue_ctrl_q <= `PSS_RST_ZERO;
         ths_low_q    <= `PSS_RST_ZERO;
         ths_high_q   <= `PSS_RST_ZERO;
         ofs_low_q    <= `PSS_RST_OFS_LOW;
         ofs_high_q   <= `PSS_RST_ZERO;
      end
      else if (wb_valid)
      begin
         // Writes to read-only or reserved addresses are dropped
         case (wb_word[14:8])
            `PSS_A_REF_LOW:    ref_low_q    <= wb_word[7:0];
            `PSS_A_REF_MID:    ref_mid_q    <= wb_word[7:0];
            `PSS_A_REF_HIGH:   ref_high_q   <= wb_word[7:0];
            `PSS_A_AVG_CFG:    avg_cfg_q    <= wb_word[7:0];
            `PSS_A_CTRL_ONE:   ctrl_one_q   <= wb_word[7:0];
            `PSS_A_CTRL_TWO:   ctrl_two_q   <= wb_word[7:0];
            `PSS_A_CTRL_THREE: ctrl_three_q <= wb_word[7:0];
            `PSS_A_CTRL_FOUR:  ctrl_four_q  <= wb_word[7:0];
            `PSS_A_IRQ_CFG:    irq_cfg_q    <= wb_word[7:0];
            `PSS_A_QUEUE_CTRL: queue_ctrl_q <= wb_word[7:0];
            `PSS_A_THS_LOW:    ths_low_q    <= wb_word[7:0];
            `PSS_A_THS_HIGH:   ths_high_q   <= wb_word[7:0];
            `PSS_A_OFS_LOW:    ofs_low_q    <= wb_word[7:0];
            `PSS_A_OFS_HIGH:   ofs_high_q   <= wb_word[7:0];
            default:           ref_low_q    <= ref_low_q;
         endcase
      end
   end

   // Reference added to sensor pressure; averaging fields decoded to counts
   always @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         o_pressure_comp         <= 24'h000000;
         o_pressure_avg_count    <= 10'd8;
         o_temperature_avg_count <= 7'd8;
      end
      else
      begin
         o_pressure_comp <= i_pressure_raw + o_ref_pressure_bits;
         case (avg_cfg_q[3:2])
            2'b00:   o_pressure_avg_count <= 10'd8;
            2'b01:   o_pressure_avg_count <= 10'd32;
            2'b10:   o_pressure_avg_count <= 10'd128;
            default: o_pressure_avg_count <= 10'd512;
         endcase
         case (avg_cfg_q[1:0])
            2'b00:   o_temperature_avg_count <= 7'd8;
            2'b01:   o_temperature_avg_count <= 7'd16;
            2'b10:   o_temperature_avg_count <= 7'd32;
            default: o_temperature_avg_count <= 7'd64;
         endcase
      end
   end

   assign o_ref_pressure_bits = {ref_high_q, ref_mid_q, ref_low_q};
   assign o_three_wire_select = ctrl_one_q[`PSS_BIT_THREE_WIRE];
   assign o_control_one       = ctrl_one_q;
   assign o_control_two       = ctrl_two_q;
   assign o_control_three     = ctrl_three_q;
   assign o_control_four      = ctrl_four_q;
   assign o_irq_config        = irq_cfg_q;
   assign o_queue_control     = queue_ctrl_q;
   assign o_threshold         = {ths_high_q, ths_low_q};
   assign o_pressure_offset   = {ofs_high_q, ofs_low_q};
endmodule // pss_spi_slave

// ### pss_spi_master.sv
// Behavioural serial master that frames transfers toward the slave port
`timescale 1ns/1ns
module pss_spi_master
#(
   parameter HALF = 6  // Serial clock half period in system clocks
)
(
   input  wire i_mclk,
   input  wire i_miso,
   output reg  o_cs_n,
   output reg  o_sclk,
   output reg  o_mosi,
   output reg  o_mosi_oe
);
   // Idle bus: select high, clock stopped high
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b1;
      o_mosi = 1'b0;
      o_mosi_oe = 1'b1;
   end

   task automatic gap;
      repeat (HALF) @(posedge i_mclk);
   endtask

   // Command byte then n data bytes, MSB first; read bytes gathered right-aligned
   task automatic xfer(input [7:0] cmd, input int n, input [31:0] wr, input bit three,
                       output [31:0] rd);
      int        i;
      reg [39:0] sh;
      sh = {cmd, wr};
      rd = 32'h0;
      @(posedge i_mclk);
      o_cs_n <= 1'b0;
      gap();
      for (i = 0; i < 8 + 8 * n; i++)
      begin
         o_sclk <= 1'b0;
         o_mosi <= sh[39 - i];
         o_mosi_oe <= !(three && cmd[7] && i >= 8);  // Shared pin handed over for read data
         gap();
         o_sclk <= 1'b1;
         gap();
         // Taken late in the high phase: the slave's bit trails the fall by its synchroniser
         if (i >= 8)
            rd = {rd[30:0], i_miso};
      end
      o_cs_n <= 1'b1;
      o_mosi_oe <= 1'b1;
      gap();
      gap();             // Select stays high long enough for the idle release check
   endtask
endmodule // pss_spi_master

// ### pss_spi_slave_properties.sv
// Concurrent checks on the serial slave port pins and register outputs
`timescale 1ns/1ns
module pss_spi_slave_props
(
   input wire        i_mclk,
   input wire        i_srst,
   input wire        i_cs_n,
   input wire        i_serial_port_clock,
   input wire        o_serial_data_out,
   input wire        o_serial_data_out_oe,
   input wire        o_serial_data_in_out,
   input wire        o_serial_data_in_oe,
   input wire [23:0] i_pressure_raw,
   input wire [23:0] o_pressure_comp,
   input wire [23:0] o_ref_pressure_bits,
   input wire [9:0]  o_pressure_avg_count,
   input wire [6:0]  o_temperature_avg_count,
   input wire        o_three_wire_select,
   input wire [7:0]  o_control_one,
   input wire [15:0] o_pressure_offset
);
   reg       sclk_q;
   reg [3:0] fall_age_q;

   // Cycles since the last serial clock fall; pin activity must follow one closely
   always @(posedge i_mclk)
   begin
      sclk_q <= i_serial_port_clock;
      if (sclk_q && !i_serial_port_clock)
         fall_age_q <= 4'h0;
      else if (fall_age_q != 4'hF)
         fall_age_q <= fall_age_q + 4'h1;
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   a_idle_release: assert property
      (i_cs_n [*8] |-> !o_serial_data_out_oe && !o_serial_data_in_oe)
      else $error("Data pins driven while select idle");
   a_drive_after_fall: assert property
      ($rose(o_serial_data_out_oe) || $rose(o_serial_data_in_oe) |-> fall_age_q <= 4'h8)
      else $error("Read data driven away from a clock fall");
   a_shift_on_fall: assert property
      (o_serial_data_out_oe && $past(o_serial_data_out_oe) && $changed(o_serial_data_out)
       |-> fall_age_q <= 4'h8)
      else $error("Read bit changed away from a clock fall");
   a_four_wire_pin: assert property
      (o_serial_data_out_oe |-> !o_three_wire_select)
      else $error("Separate output pin driven in three-wire mode");
   a_shared_pin: assert property
      (o_serial_data_in_oe |-> o_three_wire_select && o_serial_data_in_out == o_serial_data_out)
      else $error("Shared pin driven wrongly");
   a_mode_mirror: assert property
      (o_three_wire_select == o_control_one[0])
      else $error("Mode select differs from control bit");
   a_reset_vals: assert property
      (disable iff (1'b0) i_srst |=> o_control_one == 8'h00 && o_pressure_offset == 16'h0038
       && !o_serial_data_out_oe && !o_serial_data_in_oe)
      else $error("Reset values wrong");
   a_comp_sum: assert property
      (!$past(i_srst) && $stable(i_pressure_raw) && $stable(o_ref_pressure_bits)
       |-> o_pressure_comp == i_pressure_raw + o_ref_pressure_bits)
      else $error("Compensated pressure is not raw plus reference");
   a_pavg_set: assert property
      (o_pressure_avg_count inside {10'h008, 10'h020, 10'h080, 10'h200})
      else $error("Pressure average count illegal");
   a_tavg_set: assert property
      (o_temperature_avg_count inside {7'h08, 7'h10, 7'h20, 7'h40})
      else $error("Temperature average count illegal");
endmodule // pss_spi_slave_props

bind pss_spi_slave pss_spi_slave_props u_props
(
   .i_mclk(i_mclk), .i_srst(i_srst), .i_cs_n(i_cs_n), .i_serial_port_clock(i_serial_port_clock),
   .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe(o_serial_data_out_oe),
   .o_serial_data_in_out(o_serial_data_in_out), .o_serial_data_in_oe(o_serial_data_in_oe),
   .i_pressure_raw(i_pressure_raw), .o_pressure_comp(o_pressure_comp),
   .o_ref_pressure_bits(o_ref_pressure_bits), .o_pressure_avg_count(o_pressure_avg_count),
   .o_temperature_avg_count(o_temperature_avg_count), .o_three_wire_select(o_three_wire_select),
   .o_control_one(o_control_one), .o_pressure_offset(o_pressure_offset)
);

// ### pss_tb.sv
// Self-checking bench for the serial slave port driven by a behavioural master
`timescale 1ns/1ns
module testbench;
   typedef struct packed {logic wr; logic [7:0] cmd; logic [7:0] dat;} pss_row_t;
   localparam [7:0] ID_ARB = 8'hC3;  // Arbitrary identity value
   reg         mclk = 1'b0;
   reg         srst = 1'b1;
   reg         junk_q = 1'b0;
   reg  [23:0] raw_q = 24'h100000;
   reg  [31:0] rd;
   pss_row_t   rows [0:12];
   int         bad_count = 0;
   int         check_count = 0;
   int         k;
   wire        cs_n, sclk, mosi, mosi_oe, serial_data_out, sdo_oe, sio, sio_oe, three;
   wire [23:0] comp, refp;
   wire [9:0]  pavg;
   wire [6:0]  tavg;
   wire [7:0]  ctl1, c2, c3, c4, irqc, qc;
   wire [15:0] thr, ofs;
   // Undriven lines show a toggling pattern so a stale level never passes
   wire        din = sio_oe ? sio : (mosi_oe ? mosi : junk_q);
   wire        miso = three ? din : (sdo_oe ? serial_data_out : junk_q);

   // System clock
   initial
   begin
      forever #2 mclk = ~mclk;
   end

   always @(posedge mclk) junk_q <= ~junk_q;

   pss_spi_slave #(.ID_VALUE(ID_ARB)) uut
   (
      .i_mclk(mclk), .i_srst(srst), .i_cs_n(cs_n), .i_serial_port_clock(sclk),
      .i_serial_data_in(din), .o_serial_data_in_out(sio), .o_serial_data_in_oe(sio_oe),
      .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(sdo_oe), .i_pressure_raw(raw_q),
      .i_temperature(16'h1234), .i_status(8'h3C), .i_irq_source(8'h00),
      .i_queue_status(8'h00), .o_pressure_comp(comp), .o_ref_pressure_bits(refp),
      .o_pressure_avg_count(pavg), .o_temperature_avg_count(tavg),
      .o_three_wire_select(three), .o_control_one(ctl1), .o_control_two(c2),
      .o_control_three(c3), .o_control_four(c4), .o_irq_config(irqc), .o_queue_control(qc),
      .o_threshold(thr), .o_pressure_offset(ofs)
   );

   pss_spi_master m (.i_mclk(mclk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk),
                     .o_mosi(mosi), .o_mosi_oe(mosi_oe));

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watchdog well beyond the roughly six and a half thousand cycles the tests need
   initial
   begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      test_done();
   end

   // Main sequence: table of single-byte accesses, then hand-written cases
   initial
   begin
      rows[0]  = {1'b0, 8'h8F, ID_ARB};
      rows[1]  = {1'b0, 8'h90, 8'h05};
      rows[2]  = {1'b0, 8'hB9, 8'h38};
      rows[3]  = {1'b0, 8'hA7, 8'h3C};
      rows[4]  = {1'b0, 8'hAB, 8'h34};
      rows[5]  = {1'b0, 8'h91, 8'h00};
      rows[6]  = {1'b1, 8'h08, 8'hA5};
      rows[7]  = {1'b0, 8'h88, 8'hA5};
      rows[8]  = {1'b1, 8'h0F, 8'hFF};
      rows[9]  = {1'b0, 8'h8F, ID_ARB};
      rows[10] = {1'b1, 8'h24, 8'hC3};
      rows[11] = {1'b0, 8'hA4, 8'hC3};
      rows[12] = {1'b0, 8'hAA, 8'h10};
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk({14'h0, pavg}, 24'h000020);
      chk({17'h0, tavg}, 24'h000010);
      chk({8'h0, ofs}, 24'h000038);
      for (k = 0; k < 13; k++)
      begin
         m.xfer(rows[k].cmd, 1, {rows[k].dat, 24'h0}, 1'b0, rd);
         if (!rows[k].wr)
            chk({16'h0, rd[7:0]}, {16'h0, rows[k].dat});
      end
      chk({16'h0, irqc}, 24'h0000C3);
      // Burst write across the reference bytes, then the sum with raw pressure
      m.xfer(8'h48, 3, 32'h11223300, 1'b0, rd);
      chk(refp, 24'h332211);
      chk(comp, 24'h432211);
      raw_q <= 24'h0FFFFF;
      repeat (4) @(posedge mclk);
      chk(comp, 24'h432210);
      m.xfer(8'hC8, 3, 32'h0, 1'b0, rd);
      chk(rd[23:0], 24'h112233);
      m.xfer(8'h88, 2, 32'h0, 1'b0, rd);
      chk({8'h0, rd[15:0]}, 24'h001111);
      m.xfer(8'h30, 2, 32'h01020000, 1'b0, rd);
      chk({8'h0, thr}, 24'h000002);
      // Incrementing burst over control bytes two to four, then the queue control byte
      m.xfer(8'h61, 3, 32'h11223300, 1'b0, rd);
      chk({c4, c3, c2}, 24'h332211);
      m.xfer(8'h2E, 1, 32'h6B000000, 1'b0, rd);
      chk({16'h0, qc}, 24'h00006B);
      // Every averaging encoding on both fields
      for (k = 0; k < 4; k++)
      begin
         m.xfer(8'h10, 1, {4'h0, k[1:0], k[1:0], 24'h0}, 1'b0, rd);
         chk({14'h0, pavg}, 24'h000008 << (2 * k));
         chk({17'h0, tavg}, 24'h000008 << k);
      end
      // Three-wire mode with an incrementing burst read on the shared pin
      m.xfer(8'h20, 1, 32'h01000000, 1'b0, rd);
      chk({23'h0, three}, 24'h000001);
      chk({16'h0, ctl1}, 24'h000001);
      m.xfer(8'hC8, 2, 32'h0, 1'b1, rd);
      chk({8'h0, rd[15:0]}, 24'h001122);
      // Reset in mid-run returns to four-wire mode and default registers
      srst <= 1'b1;
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({23'h0, three}, 24'h000000);
      chk(refp, 24'h000000);
      m.xfer(8'h8F, 1, 32'h0, 1'b0, rd);
      chk({16'h0, rd[7:0]}, {16'h0, ID_ARB});
      test_done();
   end
endmodule // testbench
